// >>> rtl/php_host.sv
// Host (microcontroller) end: APB-controlled parallel bus master
`timescale 1ns/1ps
module php_host
  import php_pkg::*;
(
  input  wire logic        clk,     // Clock, 20 MHz
  input  wire logic        reset,   // Sync reset, high
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB enable
  input  wire logic        pwrite,  // APB direction
  input  wire logic [7:0]  paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic      [31:0] prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr, // APB error
  output logic             irq,     // Level interrupt
  php_if.host              bus      // Parallel bus pins
);
  import php_pkg::*;

  typedef enum logic [3:0] {
    PHP_S_IDLE = 4'b0001,
    PHP_S_WAIT = 4'b0010,
    PHP_S_STRB = 4'b0100,
    PHP_S_END  = 4'b1000
  } php_state_e;

  php_state_e           st_reg;
  logic [4:0]           ctrl_reg;
  logic [15:0]          wdata_reg;
  logic [15:0]          rdata_reg;
  logic [1:0]           irq_st_reg;
  logic [1:0]           irq_en_reg;
  logic [3:0]           cnt_reg;
  logic [15:0]          db_s;
  logic [1:0]           in_s;

  // Wait and interrupt idle high, so reset must not look like an interrupt
  php_sync #(.W(18), .RST_VAL(18'h00003)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({bus.host_data_bus, bus.wait_n, bus.int_n}),
    .q     ({db_s, in_s})
  );

  wire wr_acc = psel && penable && pwrite;
  wire rd_acc = psel && !penable && !pwrite;
  wire go     = wr_acc && paddr == PHP_A_CTRL && pwdata[PHP_C_GO] && st_reg == PHP_S_IDLE;
  wire done   = st_reg == PHP_S_END;

  ////////////////////////////////////////////////////////////////////////
  // APB registers; accesses finish in one access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg   <= '0;
      wdata_reg  <= '0;
      irq_en_reg <= PHP_IRQ_RST;
    end else if (wr_acc) begin
      case (paddr)
        PHP_A_CTRL:  ctrl_reg   <= pwdata[4:0];
        PHP_A_WDATA: wdata_reg  <= pwdata[15:0];
        PHP_A_IRQEN: irq_en_reg <= pwdata[1:0];
        default: ;
      endcase
    end else if (done) begin
      ctrl_reg[PHP_C_GO] <= 1'b0;
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_st_reg <= PHP_IRQ_RST;
    end else begin
      irq_st_reg <= (irq_st_reg & ~((wr_acc && paddr == PHP_A_IRQCL) ? pwdata[1:0] : 2'h0))
                    | {!in_s[0], done};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_reg & irq_en_reg);
    end
  end

  // Read mux and ready; addresses above IRQCL answer with error
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr > PHP_A_IRQCL;
      if (rd_acc) begin
        case (paddr)
          PHP_A_CTRL:  prdata <= {27'h0, ctrl_reg};
          PHP_A_WDATA: prdata <= {16'h0, wdata_reg};
          PHP_A_RDATA: prdata <= {16'h0, rdata_reg};
          PHP_A_STAT:  prdata <= {28'h0, st_reg == PHP_S_IDLE, in_s[0], in_s[1], 1'b0};
          PHP_A_IRQST: prdata <= {30'h0, irq_st_reg};
          PHP_A_IRQEN: prdata <= {30'h0, irq_en_reg};
          default:     prdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle engine: wait for ready, strobe, release
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg  <= PHP_S_IDLE;
      cnt_reg <= 4'h0;
    end else begin
      case (st_reg)
        PHP_S_IDLE: if (go) st_reg <= PHP_S_WAIT;
        PHP_S_WAIT: if (in_s[1]) begin
          st_reg  <= PHP_S_STRB;
          // Long enough for both two-flop syncs and the device's drive register
          cnt_reg <= PHP_STROBE_CNT + 4'h6;
        end
        PHP_S_STRB: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0) st_reg <= PHP_S_END;
        end
        PHP_S_END:  st_reg <= PHP_S_IDLE;
        default:    st_reg <= PHP_S_IDLE;
      endcase
    end
  end

  // Capture read data just before the strobe ends
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= '0;
    end else if (st_reg == PHP_S_STRB && cnt_reg == 4'h0 && ctrl_reg[PHP_C_RD]) begin
      rdata_reg <= ctrl_reg[PHP_C_WIDE] ? db_s : {8'h00, db_s[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive
  wire strb = st_reg == PHP_S_STRB;
  wire rd   = ctrl_reg[PHP_C_RD];
  wire s68  = ctrl_reg[PHP_C_STYLE];
  always_ff @(posedge clk) begin
    if (reset) begin
      bus.chip_sel_n         <= 1'b1;
      bus.rd_en              <= 1'b1;
      bus.wr_rw              <= 1'b1;
      bus.cmd_data_select    <= PHP_SEL_DATA;
      bus.bus_style_select   <= PHP_STYLE_8080;
      bus.port_kind_select   <= PHP_PORT_PAR;
      bus.host_data_bus_h    <= '0;
      bus.host_data_bus_h_oe <= '0;
    end else begin
      bus.bus_style_select <= s68;
      bus.cmd_data_select  <= ctrl_reg[PHP_C_SEL];
      bus.chip_sel_n       <= !(strb || st_reg == PHP_S_WAIT);
      if (s68) begin
        bus.rd_en <= strb;
        bus.wr_rw <= rd;
      end else begin
        bus.rd_en <= !(strb && rd);
        bus.wr_rw <= !(strb && !rd);
      end
      // Upper lines held low in 8-bit mode and for command writes
      bus.host_data_bus_h    <= (ctrl_reg[PHP_C_WIDE] && !ctrl_reg[PHP_C_SEL]) ?
                                wdata_reg : {8'h00, wdata_reg[7:0]};
      bus.host_data_bus_h_oe <= rd ? 16'h0000 : 16'hFFFF;
    end
  end
endmodule : php_host

// >>> rtl/php_pkg.sv
// Package of shared constants and types for the parallel host port
package php_pkg;

  // Bus widths
  localparam int PHP_BUS_W  = 16;
  localparam int PHP_REG_W  = 8;

  // Protocol straps
  localparam logic PHP_STYLE_8080  = 1'b0;
  localparam logic PHP_STYLE_6800  = 1'b1;
  localparam logic PHP_PORT_PAR    = 1'b0;
  localparam logic PHP_PORT_SER    = 1'b1;

  // Select line meanings
  localparam logic PHP_SEL_DATA    = 1'b0;
  localparam logic PHP_SEL_CMD     = 1'b1;

  // Host strobe timing: cycles of the 50 ns clock
  localparam int PHP_CLK_NS        = 50;
  localparam int PHP_STROBE_NS     = 100;
  localparam int PHP_STROBE_CYC    = (PHP_STROBE_NS + PHP_CLK_NS - 1) / PHP_CLK_NS;
  localparam logic [3:0] PHP_STROBE_CNT = 4'(PHP_STROBE_CYC);

  // Controller register offsets on APB (byte addresses)
  localparam logic [7:0] PHP_A_CTRL  = 8'h00;
  localparam logic [7:0] PHP_A_WDATA = 8'h04;
  localparam logic [7:0] PHP_A_RDATA = 8'h08;
  localparam logic [7:0] PHP_A_STAT  = 8'h0C;
  localparam logic [7:0] PHP_A_IRQST = 8'h10;
  localparam logic [7:0] PHP_A_IRQEN = 8'h14;
  localparam logic [7:0] PHP_A_IRQCL = 8'h18;

  // CTRL fields: [0] go, [1] read, [2] select, [3] style, [4] wide
  localparam int PHP_C_GO    = 0;
  localparam int PHP_C_RD    = 1;
  localparam int PHP_C_SEL   = 2;
  localparam int PHP_C_STYLE = 3;
  localparam int PHP_C_WIDE  = 4;

  // Interrupt status bits: [0] done, [1] device interrupt
  localparam int PHP_I_DONE  = 0;
  localparam int PHP_I_DEV   = 1;
  localparam logic [1:0] PHP_IRQ_RST = 2'h0;

  // Device core command kinds
  typedef enum logic [1:0] {
    PHP_K_DATA_WR = 2'h0,
    PHP_K_DATA_RD = 2'h1,
    PHP_K_CMD_WR  = 2'h2,
    PHP_K_STAT_RD = 2'h3
  } php_kind_e;

endpackage : php_pkg

// >>> rtl/php_if.sv
// Interface carrying the parallel host bus between host and device
`timescale 1ns/1ps
interface php_if;
  import php_pkg::*;
  logic [PHP_BUS_W-1:0] host_data_bus_h;    // Host drive value
  logic [PHP_BUS_W-1:0] host_data_bus_h_oe; // Host per-lane enable
  logic [PHP_BUS_W-1:0] host_data_bus_d;    // Device drive value
  logic [PHP_BUS_W-1:0] host_data_bus_d_oe; // Device per-lane enable
  logic [PHP_BUS_W-1:0] host_data_bus;      // Resolved level
  logic                 chip_sel_n;         // Chip select, low active
  logic                 rd_en;              // 8080 read low / 6800 enable high
  logic                 wr_rw;              // 8080 write low / 6800 read high
  logic                 cmd_data_select;    // 0 data, 1 command/status
  logic                 bus_style_select;   // 0 8080, 1 6800
  logic                 port_kind_select;   // 0 parallel, 1 serial
  logic                 int_n;              // Interrupt, low active
  logic                 wait_n;             // Busy, low active

  // Undriven lanes read low, standing in for board pull-downs
  assign host_data_bus = (host_data_bus_h & host_data_bus_h_oe) |
                         (host_data_bus_d & host_data_bus_d_oe);

  modport host (output host_data_bus_h, host_data_bus_h_oe, chip_sel_n, rd_en, wr_rw,
                output cmd_data_select, bus_style_select, port_kind_select,
                input host_data_bus, int_n, wait_n);
  modport device (output host_data_bus_d, host_data_bus_d_oe, int_n, wait_n,
                  input host_data_bus, chip_sel_n, rd_en, wr_rw, cmd_data_select,
                  input bus_style_select, port_kind_select);
endinterface : php_if

// >>> rtl/php_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module php_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,   // Clock
  input  wire logic         reset, // Sync reset, high
  input  wire logic [W-1:0] d,     // Asynchronous input
  output logic      [W-1:0] q      // Synchronised output
);
  logic [W-1:0] meta_reg;

  // First stage is read only by the second; reset to the pin's idle level
  // so that no false edge shows just after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : php_sync

// >>> rtl/php_device.sv
// Device end of the parallel host port
`timescale 1ns/1ps
module php_device
  import php_pkg::*;
#(
  parameter int BUSY_CYC = 4
) (
  input  wire logic                   clk,          // Clock, 20 MHz
  input  wire logic                   reset,        // Sync reset, high
  php_if.device                       bus,          // Parallel bus pins
  input  wire logic                   wide_mode,    // 1: 16-bit display data
  output logic                        cmd_valid,    // Core command pulse
  output php_pkg::php_kind_e          cmd_kind,     // Kind of command
  output logic [php_pkg::PHP_BUS_W-1:0] cmd_wdata,  // Written value
  input  wire logic [php_pkg::PHP_BUS_W-1:0] rd_data, // Display read data
  input  wire logic [php_pkg::PHP_REG_W-1:0] status, // Status byte
  input  wire logic                   core_busy,    // Core cannot take cycles
  input  wire logic                   core_irq      // Core interrupt level
);
  import php_pkg::*;

  logic [PHP_BUS_W-1:0] db_s;
  logic [5:0]           ctl_s;
  logic                 act_reg;
  logic [3:0]           busy_cnt_reg;
  logic                 strobe_d_reg;

  php_sync #(.W(PHP_BUS_W)) u_sync_db (
    .clk   (clk),
    .reset (reset),
    .d     (bus.host_data_bus),
    .q     (db_s)
  );

  // Idle levels: chip select, read and write strobes high
  php_sync #(.W(6), .RST_VAL(6'h38)) u_sync_ctl (
    .clk   (clk),
    .reset (reset),
    .d     ({bus.chip_sel_n, bus.rd_en, bus.wr_rw, bus.cmd_data_select,
             bus.bus_style_select, bus.port_kind_select}),
    .q     (ctl_s)
  );

  wire cs_n  = ctl_s[5];
  wire rden  = ctl_s[4];
  wire wrrw  = ctl_s[3];
  wire sel   = ctl_s[2];
  wire style = ctl_s[1];
  wire pkind = ctl_s[0];

  // Decode strobes per style into one active level and a direction
  wire is_rd  = (style == PHP_STYLE_6800) ? wrrw : !rden;
  wire active = (style == PHP_STYLE_6800) ? rden : (!rden || !wrrw);
  // Cycle only counts on parallel port with chip select low
  wire cyc    = active && !cs_n && (pkind == PHP_PORT_PAR);
  wire busy   = core_busy || (busy_cnt_reg != 4'h0);

  ////////////////////////////////////////////////////////////////////////
  // Cycle tracking: a new cycle is taken only when not busy
  always_ff @(posedge clk) begin
    if (reset) begin
      act_reg <= 1'b0;
    end else begin
      act_reg <= cyc && (act_reg || !busy);
    end
  end

  // Write takes effect at the trailing edge; read starts at leading edge
  wire start = cyc && !act_reg && !busy;
  wire stop  = act_reg && !cyc;
  always_ff @(posedge clk) begin
    if (reset) begin
      strobe_d_reg <= 1'b0;
    end else begin
      strobe_d_reg <= is_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command pulse to the core
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_valid <= 1'b0;
      cmd_kind  <= PHP_K_DATA_WR;
      cmd_wdata <= '0;
    end else begin
      cmd_valid <= 1'b0;
      if (start && is_rd) begin
        cmd_valid <= 1'b1;
        cmd_kind  <= (sel == PHP_SEL_CMD) ? PHP_K_STAT_RD : PHP_K_DATA_RD;
      end else if (stop && !strobe_d_reg) begin
        cmd_valid <= 1'b1;
        cmd_kind  <= (sel == PHP_SEL_CMD) ? PHP_K_CMD_WR : PHP_K_DATA_WR;
        if (sel == PHP_SEL_CMD || !wide_mode) begin
          cmd_wdata <= {8'h00, db_s[7:0]};
        end else begin
          cmd_wdata <= db_s;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Busy hold after each cycle gives the core time to act
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_cnt_reg <= 4'h0;
    end else if (stop) begin
      busy_cnt_reg <= 4'(BUSY_CYC);
    end else if (busy_cnt_reg != 4'h0) begin
      busy_cnt_reg <= busy_cnt_reg - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read drive: low byte always, upper byte only for wide display reads
  always_ff @(posedge clk) begin
    if (reset) begin
      bus.host_data_bus_d    <= '0;
      bus.host_data_bus_d_oe <= '0;
    end else if (act_reg && is_rd && cyc) begin
      if (sel == PHP_SEL_CMD) begin
        bus.host_data_bus_d    <= {8'h00, status};
        bus.host_data_bus_d_oe <= 16'h00FF;
      end else if (wide_mode) begin
        bus.host_data_bus_d    <= rd_data;
        bus.host_data_bus_d_oe <= 16'hFFFF;
      end else begin
        bus.host_data_bus_d    <= {8'h00, rd_data[7:0]};
        bus.host_data_bus_d_oe <= 16'h00FF;
      end
    end else begin
      bus.host_data_bus_d_oe <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wait and interrupt outputs, both low active
  always_ff @(posedge clk) begin
    if (reset) begin
      bus.wait_n <= 1'b1;
      bus.int_n  <= 1'b1;
    end else begin
      bus.wait_n <= !busy;
      bus.int_n  <= !core_irq;
    end
  end
endmodule : php_device

// >>> verification/php_monitor.sv
// Checker on the parallel bus that joins the host and device ends
`timescale 1ns/1ps
module php_monitor (
  input wire logic                          clk,                // Clock
  input wire logic                          reset,              // Sync reset, high
  input wire logic [php_pkg::PHP_BUS_W-1:0] host_data_bus_h_oe, // Host lane enables
  input wire logic [php_pkg::PHP_BUS_W-1:0] host_data_bus_d_oe, // Device lane enables
  input wire logic                          chip_sel_n,         // Chip select, low
  input wire logic                          rd_en,              // Read strobe or enable
  input wire logic                          wr_rw,              // Write strobe or direction
  input wire logic                          cmd_data_select,    // Data or command
  input wire logic                          bus_style_select,   // Protocol strap
  input wire logic                          port_kind_select,   // Parallel or serial strap
  input wire logic                          wait_n              // Busy, low
);
  import php_pkg::*;
  logic st_q1;
  logic st_q2;
  logic s80;
  logic s68;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////////
  // Style history: idle strobe levels differ per style, so skip cycles near a switch
  always_ff @(posedge clk) begin
    st_q1 <= bus_style_select;
    st_q2 <= st_q1;
  end
  assign s80 = (bus_style_select == PHP_STYLE_8080) && (st_q1 == PHP_STYLE_8080)
               && (st_q2 == PHP_STYLE_8080);
  assign s68 = (bus_style_select == PHP_STYLE_6800) && (st_q1 == PHP_STYLE_6800)
               && (st_q2 == PHP_STYLE_6800);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus ownership and strobe shape
  cs_gate_a : assert property (
    (chip_sel_n && $past(chip_sel_n) && $past(chip_sel_n, 2) && $past(chip_sel_n, 3))
    |-> host_data_bus_d_oe == '0)
    else $error("device drives bus while deselected");
  no_fight_a : assert property (
    (host_data_bus_h_oe & host_data_bus_d_oe) == '0)
    else $error("both ends drive one lane");
  reg_low_a : assert property (
    host_data_bus_d_oe[15:8] != 8'h00 |-> cmd_data_select == PHP_SEL_DATA)
    else $error("upper lanes driven on a command cycle");
  strobe_cs_a : assert property (
    (s80 && (!rd_en || !wr_rw)) |-> !chip_sel_n)
    else $error("strobe without chip select");
  one_strobe_a : assert property (
    s80 |-> (rd_en || wr_rw))
    else $error("read and write strobes together");
  dir_hold_a : assert property (
    (s68 && rd_en && $past(rd_en)) |-> ($stable(wr_rw) && $stable(cmd_data_select)))
    else $error("direction moved inside enable");
  busy_after_a : assert property (
    (s80 && $rose(wr_rw) && $past(!chip_sel_n)) |-> ##[1:6] !wait_n)
    else $error("no busy after a write cycle");
  read80_a : assert property (
    (s80 && $fell(rd_en) && !chip_sel_n && wait_n) |-> ##[2:6] host_data_bus_d_oe[7:0] == 8'hFF)
    else $error("no read data on a read strobe");
  read68_a : assert property (
    (s68 && $rose(rd_en) && wr_rw && !chip_sel_n && wait_n)
    |-> ##[2:6] host_data_bus_d_oe[7:0] == 8'hFF)
    else $error("no read data on a 6800 read");
  strap_a : assert property (
    $stable(port_kind_select) && port_kind_select == PHP_PORT_PAR)
    else $error("port strap moved");

  // Main scenarios reached
  c_rd80 : cover property (s80 && $fell(rd_en) && !chip_sel_n);
  c_rd68 : cover property (s68 && $rose(rd_en) && wr_rw);
  c_wide : cover property (host_data_bus_d_oe[15:8] == 8'hFF);
  c_busy : cover property (!wait_n && chip_sel_n);
endmodule : php_monitor

// >>> verification/parallel_mcu_host_port_tb.sv
// Bench joining host and device ends, driven through the host's APB registers
`timescale 1ns/1ps
module parallel_mcu_host_port_tb;
  import php_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  logic        pready, pslverr, irq, rerr, cmd_valid;
  logic        wide_mode = 1'b0, core_busy = 1'b0, core_irq = 1'b0;
  logic [15:0] rd_data = 16'h0000, cmd_wdata, cap_wdata, wd, m;
  logic [7:0]  status = 8'h00;
  logic        s, w, sel, r;
  php_kind_e   cmd_kind, cap_kind;
  int          cap_n = 0, n0, cyc = 0, bad_count = 0, cmp_count = 0;

  always #25 clk = ~clk;

  php_if php_if_inst ();
  php_host php_host_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .bus(php_if_inst));
  php_device #(.BUSY_CYC(4)) php_device_inst (.clk(clk), .reset(reset), .bus(php_if_inst),
    .wide_mode(wide_mode), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .status(status), .core_busy(core_busy),
    .core_irq(core_irq));
  php_monitor php_monitor_inst (.clk(clk), .reset(reset),
    .host_data_bus_h_oe(php_if_inst.host_data_bus_h_oe),
    .host_data_bus_d_oe(php_if_inst.host_data_bus_d_oe),
    .chip_sel_n(php_if_inst.chip_sel_n), .rd_en(php_if_inst.rd_en),
    .wr_rw(php_if_inst.wr_rw), .cmd_data_select(php_if_inst.cmd_data_select),
    .bus_style_select(php_if_inst.bus_style_select),
    .port_kind_select(php_if_inst.port_kind_select), .wait_n(php_if_inst.wait_n));

  ////////////////////////////////////////////////////////////////////////////////
  // Capture core commands; count cycles so a hang still reaches the verdict
  always @(posedge clk) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      cap_kind = cmd_kind;
      cap_wdata = cmd_wdata;
      cap_n++;
    end
    if (cyc == 20000) begin
      bad_count++;
      close_out;
    end
  end

  task close_out;
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Go self-clears at done; then let the fixed busy time and its sync run out
  task wait_done;
    do apb(1'b0, PHP_A_CTRL, 32'h0); while (rq[PHP_C_GO] !== 1'b0);
    repeat (8) @(posedge clk);
  endtask : wait_done

  task start(input logic [15:0] d);
    wide_mode <= w;
    apb(1'b1, PHP_A_WDATA, {16'h0000, d});
    apb(1'b1, PHP_A_CTRL, {27'h0, w, s, sel, r, 1'b1});
  endtask : start

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, PHP_A_IRQST, 32'h0);
    chk(rq, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk(rerr, 1'b1);
    // Every kind of cycle in both styles and both widths
    for (int i = 0; i < 16; i++) begin
      {sel, r, w, s} = 4'(i);
      wd = 16'hB7E1 + 16'(i);
      rd_data <= ~wd;
      status <= 8'h40 + 8'(i);
      n0 = cap_n;
      start(wd);
      wait_done;
      chk(32'(cap_n), 32'(n0 + 1));
      chk(32'(cap_kind), {30'h0, sel, r});
      m = (sel || !w) ? 16'h00FF : 16'hFFFF;
      if (!r) chk(cap_wdata & m, wd & m);
      else apb(1'b0, PHP_A_RDATA, 32'h0);
      if (r) chk(rq[15:0], sel ? {8'h00, status} : (rd_data & m));
    end
    // Busy core holds the cycle off until it clears
    {sel, r, w, s} = 4'h0;
    core_busy <= 1'b1;
    n0 = cap_n;
    start(16'h3C5A);
    repeat (20) @(posedge clk);
    chk(32'(cap_n), 32'(n0));
    chk(php_if_inst.wait_n, 1'b0);
    core_busy <= 1'b0;
    wait_done;
    chk(32'(cap_n), 32'(n0 + 1));
    // Done is sticky and masked until enabled, then cleared
    apb(1'b0, PHP_A_IRQST, 32'h0);
    chk(rq[1:0], 2'h1);
    chk(irq, 1'b0);
    apb(1'b1, PHP_A_IRQEN, 32'h1);
    apb(1'b0, PHP_A_IRQST, 32'h0);
    chk(irq, 1'b1);
    apb(1'b1, PHP_A_IRQCL, 32'h1);
    apb(1'b0, PHP_A_IRQST, 32'h0);
    chk(rq[1:0], 2'h0);
    chk(irq, 1'b0);
    // Device interrupt reaches the pin and the sticky bit
    core_irq <= 1'b1;
    repeat (2) apb(1'b0, PHP_A_STAT, 32'h0);
    chk(php_if_inst.int_n, 1'b0);
    chk(rq[2], 1'b0);
    core_irq <= 1'b0;
    apb(1'b1, PHP_A_IRQEN, 32'h2);
    repeat (2) apb(1'b0, PHP_A_IRQST, 32'h0);
    chk(rq[1:0], 2'h2);
    chk(irq, 1'b1);
    apb(1'b1, PHP_A_IRQCL, 32'h2);
    apb(1'b0, PHP_A_IRQST, 32'h0);
    chk(irq, 1'b0);
    close_out;
  end
endmodule : parallel_mcu_host_port_tb
